// ### converter_control_pkg.sv
package converter_control_pkg;

  // Special-function register address and reset value.
  localparam logic [7:0] CTRL_STATUS_ADDR = 8'h00_E8;
  localparam logic [7:0] CTRL_STATUS_RESET = 8'h00_00;

  // Field positions inside the control/status byte.
  localparam int POWER_ON_BIT = 7;
  localparam int TRACK_MODE_BIT = 6;
  localparam int DONE_FLAG_BIT = 5;
  localparam int CONVERTING_BIT = 4;
  localparam int SOURCE_HI_BIT = 3;
  localparam int SOURCE_LO_BIT = 2;
  localparam int WINDOW_FLAG_BIT = 1;
  localparam int LEFT_ALIGN_BIT = 0;

  // Start-source codes.
  localparam logic [1:0] SRC_SOFTWARE = 2'h0;
  localparam logic [1:0] SRC_TIMER3 = 2'h1;
  localparam logic [1:0] SRC_STROBE = 2'h2;
  localparam logic [1:0] SRC_TIMER2 = 2'h3;

  // Timing, in converter clocks and system clocks.
  localparam int TRACK_SAR_CLKS = 3;
  localparam int CONV_SAR_CLKS = 16;
  localparam int SAR_CLK_DIV = 4;
  localparam int SEQ_COUNT_W = 5;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_TRACK = 3'b010,
    SEQ_CONVERT = 3'b100
  } seq_state_t;

endpackage

// ### conv_seq_if.sv
`timescale 1ns/10ps
`default_nettype none

interface conv_seq_if;
  logic powerOn;
  logic startReq;
  logic skipTrack;
  logic sarTick;
  logic busy;
  logic tracking;
  logic converting;
  logic convEnd;

  modport ctrl (
    output powerOn,
    output startReq,
    output skipTrack,
    input sarTick,
    input busy,
    input tracking,
    input converting,
    input convEnd
  );

  modport seq (
    input powerOn,
    input startReq,
    input skipTrack,
    input sarTick,
    output busy,
    output tracking,
    output converting,
    output convEnd
  );
endinterface

`default_nettype wire

// ### sar_tick_divider.sv
`timescale 1ns/10ps
`default_nettype none

module sar_tick_divider
  import converter_control_pkg::*;
#(
  parameter int DIV = SAR_CLK_DIV
)
(
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Control.
  input wire logic run,
  // Converter clock enable.
  output logic tick
);

  logic [7:0] count_reg;
  logic [7:0] count_next;
  logic tick_reg;
  logic tick_next;

  always_comb
  begin
    count_next = 8'h00_00;
    tick_next = 1'b0;
    if (run)
    begin
      if (count_reg == 8'(DIV - 1))
      begin
        tick_next = 1'b1;
      end
      else
      begin
        count_next = count_reg + 8'h00_01;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      count_reg <= 8'h00_00;
      tick_reg <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;

endmodule

`default_nettype wire

// ### conversion_sequencer.sv
`timescale 1ns/10ps
`default_nettype none

module conversion_sequencer
  import converter_control_pkg::*;
#(
  parameter int TRACK_CLKS = TRACK_SAR_CLKS,
  parameter int CONV_CLKS = CONV_SAR_CLKS
)
(
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Link to the control register.
  conv_seq_if.seq link
);

  seq_state_t state_reg;
  seq_state_t state_next;
  logic [SEQ_COUNT_W-1:0] count_reg;
  logic [SEQ_COUNT_W-1:0] count_next;
  logic convEnd_reg;
  logic convEnd_next;

  always_comb
  begin
    state_next = state_reg;
    count_next = count_reg;
    convEnd_next = 1'b0;
    case (state_reg)
      SEQ_IDLE:
      begin
        count_next = '0;
        // Start events while powered off or busy never reach this branch.
        if (link.powerOn && link.startReq)
        begin
          state_next = link.skipTrack ? SEQ_CONVERT : SEQ_TRACK;
        end
      end
      SEQ_TRACK:
      begin
        if (link.sarTick)
        begin
          if (count_reg == SEQ_COUNT_W'(TRACK_CLKS - 1))
          begin
            count_next = '0;
            state_next = SEQ_CONVERT;
          end
          else
          begin
            count_next = count_reg + 1'b1;
          end
        end
      end
      SEQ_CONVERT:
      begin
        if (link.sarTick)
        begin
          if (count_reg == SEQ_COUNT_W'(CONV_CLKS - 1))
          begin
            count_next = '0;
            convEnd_next = 1'b1;
            state_next = SEQ_IDLE;
          end
          else
          begin
            count_next = count_reg + 1'b1;
          end
        end
      end
      default:
      begin
        state_next = SEQ_IDLE;
        count_next = '0;
      end
    endcase
    // Shutdown aborts any sequence without pulsing convEnd; the falling busy still raises conversionIrq.
    if (!link.powerOn)
    begin
      state_next = SEQ_IDLE;
      count_next = '0;
      convEnd_next = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg <= SEQ_IDLE;
      count_reg <= '0;
      convEnd_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      count_reg <= count_next;
      convEnd_reg <= convEnd_next;
    end
  end

  assign link.busy = (state_reg != SEQ_IDLE);
  assign link.tracking = (state_reg == SEQ_TRACK);
  assign link.converting = (state_reg == SEQ_CONVERT);
  assign link.convEnd = convEnd_reg;

endmodule

`default_nettype wire

// ### converter_control.sv
`timescale 1ns/10ps
`default_nettype none

module converter_control
  import converter_control_pkg::*;
#(
  parameter int SAR_DIV = SAR_CLK_DIV,
  parameter int TRACK_CLKS = TRACK_SAR_CLKS,
  parameter int CONV_CLKS = CONV_SAR_CLKS
)
(
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Special-function register port.
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWrite,
  input wire logic [7:0] sfrWrData,
  input wire logic sfrRead,
  output logic [7:0] sfrRdData,
  // Start sources.
  input wire logic timer2Overflow,
  input wire logic timer3Overflow,
  input wire logic external_convert_strobe,
  // Converter datapath and interrupt controller.
  input wire logic windowMatch,
  input wire logic convIrqEnable,
  output logic converterPowered,
  output logic trackActive,
  output logic convertActive,
  output logic leftAligned,
  output logic conversionIrq
);

  ////////////////////////////////////////////////////////////////////////////
  // Control and status register.

  logic converter_power_on_reg;
  logic converter_power_on_next;
  logic track_mode_select_reg;
  logic track_mode_select_next;
  logic [1:0] start_source_select_reg;
  logic [1:0] start_source_select_next;
  logic conversion_done_flag_reg;
  logic conversion_done_flag_next;
  logic window_hit_flag_reg;
  logic window_hit_flag_next;
  logic left_align_select_reg;
  logic left_align_select_next;
  logic strobePrev_reg;
  logic busyPrev_reg;
  logic ctrlWrite;
  logic swStart;
  logic strobeRise;
  logic startEvent;
  logic trackNow;
  logic [7:0] statusByte;
  logic strobePrev_next;
  logic busyPrev_next;
  logic [7:0] sfrRdData_next;
  logic converterPowered_next;
  logic trackActive_next;
  logic convertActive_next;
  logic leftAligned_next;
  logic conversionIrq_next;

  conv_seq_if link();

  function automatic logic hit(input logic [7:0] addr);
    hit = (addr == CTRL_STATUS_ADDR);
  endfunction

  // The strobe source is the one whose tracking the sequencer does not time.
  function automatic logic strobeSourced(input logic [1:0] src);
    strobeSourced = (src == SRC_STROBE);
  endfunction

  assign ctrlWrite = sfrWrite && hit(sfrAddr);

  // Each field lands at its own position, so a layout change touches the package only.
  always_comb
  begin
    statusByte = 8'h00;
    statusByte[POWER_ON_BIT] = converter_power_on_reg;
    statusByte[TRACK_MODE_BIT] = track_mode_select_reg;
    statusByte[DONE_FLAG_BIT] = conversion_done_flag_reg;
    statusByte[CONVERTING_BIT] = link.busy;
    statusByte[SOURCE_HI_BIT:SOURCE_LO_BIT] = start_source_select_reg;
    statusByte[WINDOW_FLAG_BIT] = window_hit_flag_reg;
    statusByte[LEFT_ALIGN_BIT] = left_align_select_reg;
  end

  // Software-owned fields change only on a write to the register.
  always_comb
  begin
    converter_power_on_next = converter_power_on_reg;
    track_mode_select_next = track_mode_select_reg;
    start_source_select_next = start_source_select_reg;
    left_align_select_next = left_align_select_reg;
    if (ctrlWrite)
    begin
      converter_power_on_next = sfrWrData[POWER_ON_BIT];
      track_mode_select_next = sfrWrData[TRACK_MODE_BIT];
      start_source_select_next = sfrWrData[SOURCE_HI_BIT:SOURCE_LO_BIT];
      left_align_select_next = sfrWrData[LEFT_ALIGN_BIT];
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      converter_power_on_reg <= CTRL_STATUS_RESET[POWER_ON_BIT];
      track_mode_select_reg <= CTRL_STATUS_RESET[TRACK_MODE_BIT];
      start_source_select_reg <= CTRL_STATUS_RESET[SOURCE_HI_BIT:SOURCE_LO_BIT];
      left_align_select_reg <= CTRL_STATUS_RESET[LEFT_ALIGN_BIT];
    end
    else
    begin
      converter_power_on_reg <= converter_power_on_next;
      track_mode_select_reg <= track_mode_select_next;
      start_source_select_reg <= start_source_select_next;
      left_align_select_reg <= left_align_select_next;
    end
  end

  // The flags are written by software but set by hardware.
  always_comb
  begin
    conversion_done_flag_next = conversion_done_flag_reg;
    window_hit_flag_next = window_hit_flag_reg;
    if (ctrlWrite)
    begin
      conversion_done_flag_next = sfrWrData[DONE_FLAG_BIT];
      window_hit_flag_next = sfrWrData[WINDOW_FLAG_BIT];
    end
    // Hardware set wins over a software clear in the same cycle.
    if (link.convEnd)
    begin
      conversion_done_flag_next = 1'b1;
      if (windowMatch)
      begin
        window_hit_flag_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      conversion_done_flag_reg <= CTRL_STATUS_RESET[DONE_FLAG_BIT];
      window_hit_flag_reg <= CTRL_STATUS_RESET[WINDOW_FLAG_BIT];
    end
    else
    begin
      conversion_done_flag_reg <= conversion_done_flag_next;
      window_hit_flag_reg <= window_hit_flag_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Start selection.

  // A written one starts only if the written source code is software.
  assign swStart = ctrlWrite && sfrWrData[CONVERTING_BIT] &&
                   (sfrWrData[SOURCE_HI_BIT:SOURCE_LO_BIT] == SRC_SOFTWARE);
  assign strobeRise = external_convert_strobe && !strobePrev_reg;

  always_comb
  begin
    case (start_source_select_reg)
      SRC_SOFTWARE: startEvent = swStart;
      SRC_TIMER3: startEvent = timer3Overflow;
      SRC_STROBE: startEvent = strobeRise;
      SRC_TIMER2: startEvent = timer2Overflow;
      default: startEvent = 1'b0;
    endcase
  end

  assign link.powerOn = converter_power_on_reg;
  // A start that meets a busy sequencer is dropped, never queued.
  assign link.startReq = startEvent && !link.busy;
  // The tracking phase is skipped where tracking is not timed by the sequencer.
  assign link.skipTrack = !track_mode_select_reg ||
                          strobeSourced(start_source_select_reg);

  always_comb
  begin
    trackNow = 1'b0;
    if (converter_power_on_reg)
    begin
      if (!track_mode_select_reg)
      begin
        trackNow = !link.converting;
      end
      else if (strobeSourced(start_source_select_reg))
      begin
        trackNow = !external_convert_strobe && !link.busy;
      end
      else
      begin
        trackNow = link.tracking;
      end
    end
  end

  // The converter clock runs only during a sequence, so each start sees the same phase.
  sar_tick_divider #(
    .DIV(SAR_DIV)
  ) divider (
    .clk(clk),
    .nrst(nrst),
    .run(link.busy),
    .tick(link.sarTick)
  );

  conversion_sequencer #(
    .TRACK_CLKS(TRACK_CLKS),
    .CONV_CLKS(CONV_CLKS)
  ) sequencer (
    .clk(clk),
    .nrst(nrst),
    .link(link)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs.

  // Edge detectors for the strobe start and the interrupt.
  always_comb
  begin
    strobePrev_next = external_convert_strobe;
    busyPrev_next = link.busy;
  end

  // The strobe history resets to the pin's idle high level, so reset release is no rising edge.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      strobePrev_reg <= 1'b1;
      busyPrev_reg <= 1'b0;
    end
    else
    begin
      strobePrev_reg <= strobePrev_next;
      busyPrev_reg <= busyPrev_next;
    end
  end

  always_comb
  begin
    sfrRdData_next = sfrRdData;
    if (sfrRead)
    begin
      sfrRdData_next = hit(sfrAddr) ? statusByte : 8'h00;
    end
    converterPowered_next = converter_power_on_reg;
    trackActive_next = trackNow;
    convertActive_next = link.converting;
    leftAligned_next = left_align_select_reg;
    conversionIrq_next = busyPrev_reg && !link.busy && convIrqEnable;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sfrRdData <= 8'h00;
      converterPowered <= 1'b0;
      trackActive <= 1'b0;
      convertActive <= 1'b0;
      leftAligned <= 1'b0;
      conversionIrq <= 1'b0;
    end
    else
    begin
      sfrRdData <= sfrRdData_next;
      converterPowered <= converterPowered_next;
      trackActive <= trackActive_next;
      convertActive <= convertActive_next;
      leftAligned <= leftAligned_next;
      conversionIrq <= conversionIrq_next;
    end
  end

endmodule

`default_nettype wire

// ### converter_control_properties.sv
`timescale 1ns/10ps
`default_nettype none

module converter_control_properties
  import converter_control_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Register port.
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWrite,
  input wire logic [7:0] sfrWrData,
  input wire logic sfrRead,
  input wire logic [7:0] sfrRdData,
  // Start sources and datapath.
  input wire logic timer2Overflow,
  input wire logic timer3Overflow,
  input wire logic external_convert_strobe,
  input wire logic windowMatch,
  input wire logic convIrqEnable,
  input wire logic converterPowered,
  input wire logic trackActive,
  input wire logic convertActive,
  input wire logic leftAligned,
  input wire logic conversionIrq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  a_irq_single: assert property (conversionIrq |=> !conversionIrq)
    else $error("interrupt pulse longer than one cycle");
  a_irq_gated: assert property (!convIrqEnable && !$past(convIrqEnable) |-> !conversionIrq)
    else $error("interrupt while disabled");
  a_power_follows: assert property (sfrWrite && sfrAddr == CTRL_STATUS_ADDR ##1 !sfrWrite
    |=> converterPowered == $past(sfrWrData[POWER_ON_BIT], 2))
    else $error("power output does not follow written bit");
  a_align_follows: assert property (sfrWrite && sfrAddr == CTRL_STATUS_ADDR ##1 !sfrWrite
    |=> leftAligned == $past(sfrWrData[LEFT_ALIGN_BIT], 2))
    else $error("alignment output does not follow written bit");
  a_off_quiet: assert property (!converterPowered [*3] |-> !convertActive && !trackActive)
    else $error("activity while powered down");
  a_phases_apart: assert property (!(trackActive && convertActive))
    else $error("tracking and converting together");
  a_unmapped_zero: assert property (sfrRead && sfrAddr != CTRL_STATUS_ADDR |=> sfrRdData == 8'h00)
    else $error("unmapped read not zero");
  a_rd_holds: assert property (!sfrRead |=> $stable(sfrRdData))
    else $error("read data changed without read");
  a_busy_reads: assert property (sfrRead && sfrAddr == CTRL_STATUS_ADDR ##1 convertActive
    |-> sfrRdData[CONVERTING_BIT])
    else $error("busy bit low during conversion");

  c_irq: cover property (conversionIrq);
  c_track_then_convert: cover property (trackActive ##1 convertActive);
  c_unmapped: cover property (sfrRead && sfrAddr != CTRL_STATUS_ADDR);
endmodule

bind converter_control converter_control_properties props (
  .clk(clk),
  .nrst(nrst),
  .sfrAddr(sfrAddr),
  .sfrWrite(sfrWrite),
  .sfrWrData(sfrWrData),
  .sfrRead(sfrRead),
  .sfrRdData(sfrRdData),
  .timer2Overflow(timer2Overflow),
  .timer3Overflow(timer3Overflow),
  .external_convert_strobe(external_convert_strobe),
  .windowMatch(windowMatch),
  .convIrqEnable(convIrqEnable),
  .converterPowered(converterPowered),
  .trackActive(trackActive),
  .convertActive(convertActive),
  .leftAligned(leftAligned),
  .conversionIrq(conversionIrq)
);

`default_nettype wire

// ### start_source_model.sv
`timescale 1ns/10ps
`default_nettype none

module start_source_model
(
  // Clock.
  input wire logic clk,
  // Start events toward the converter.
  output logic timer2Overflow,
  output logic timer3Overflow,
  output logic external_convert_strobe
);
  initial
  begin
    timer2Overflow = 1'b0;
    timer3Overflow = 1'b0;
    external_convert_strobe = 1'b1;
  end

  // Bit 0 pulses the third timer, bit 1 the second, for one cycle.
  task automatic fire(input logic [1:0] which);
    @(negedge clk);
    timer3Overflow = which[0];
    timer2Overflow = which[1];
    @(negedge clk);
    timer3Overflow = 1'b0;
    timer2Overflow = 1'b0;
  endtask

  task automatic strobe(input logic level);
    @(negedge clk);
    external_convert_strobe = level;
  endtask
endmodule

`default_nettype wire

// ### converter_control_test.sv
`timescale 1ns/10ps
`default_nettype none

module converter_control_test;
  import converter_control_pkg::*;
  logic clk, nrst, sfrWrite, sfrRead, windowMatch, convIrqEnable;
  logic [7:0] sfrAddr, sfrWrData, sfrRdData;
  logic timer2Overflow, timer3Overflow, external_convert_strobe;
  logic converterPowered, trackActive, convertActive, leftAligned, conversionIrq;
  int fails, checked;

  converter_control uut (
    .clk(clk),
    .nrst(nrst),
    .sfrAddr(sfrAddr),
    .sfrWrite(sfrWrite),
    .sfrWrData(sfrWrData),
    .sfrRead(sfrRead),
    .sfrRdData(sfrRdData),
    .timer2Overflow(timer2Overflow),
    .timer3Overflow(timer3Overflow),
    .external_convert_strobe(external_convert_strobe),
    .windowMatch(windowMatch),
    .convIrqEnable(convIrqEnable),
    .converterPowered(converterPowered),
    .trackActive(trackActive),
    .convertActive(convertActive),
    .leftAligned(leftAligned),
    .conversionIrq(conversionIrq)
  );
  start_source_model partner (
    .clk(clk),
    .timer2Overflow(timer2Overflow),
    .timer3Overflow(timer3Overflow),
    .external_convert_strobe(external_convert_strobe)
  );

  task automatic tally_and_finish;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge clk);
    sfrAddr = a;
    sfrWrData = d;
    sfrWrite = 1'b1;
    @(negedge clk);
    sfrWrite = 1'b0;
  endtask

  task automatic rd(logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    sfrAddr = a;
    sfrRead = 1'b1;
    @(negedge clk);
    sfrRead = 1'b0;
    @(negedge clk);
    d = sfrRdData;
  endtask

  task automatic wait_irq;
    int n;
    n = 0;
    while (conversionIrq !== 1'b1 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    check("irq seen", 1'b1, conversionIrq);
  endtask

  task automatic s_power;
    logic [7:0] d;
    int n;
    rd(CTRL_STATUS_ADDR, d);
    check("reset value", CTRL_STATUS_RESET, d);
    wr(8'h12, 8'hFF);
    rd(8'h12, d);
    check("unmapped", 8'h00, d);
    wr(CTRL_STATUS_ADDR, 8'h90);
    rd(CTRL_STATUS_ADDR, d);
    check("start while off", 8'h80, d);
    check("powered", 1'b1, converterPowered);
    check("idle track", 1'b1, trackActive);
    windowMatch = 1'b1;
    wr(CTRL_STATUS_ADDR, 8'h91);
    rd(CTRL_STATUS_ADDR, d);
    check("busy read", 8'h91, d);
    check("no track busy", 1'b0, trackActive);
    check("left", 1'b1, leftAligned);
    wait_irq;
    windowMatch = 1'b0;
    rd(CTRL_STATUS_ADDR, d);
    check("flags", 8'hA3, d);
    wr(CTRL_STATUS_ADDR, 8'h80);
    rd(CTRL_STATUS_ADDR, d);
    check("cleared", 8'h80, d);
    convIrqEnable = 1'b0;
    wr(CTRL_STATUS_ADDR, 8'h90);
    n = 0;
    repeat (150) @(negedge clk) n += conversionIrq;
    convIrqEnable = 1'b1;
    check("masked irq", 8'h00, n[7:0]);
    rd(CTRL_STATUS_ADDR, d);
    check("done", 8'hA0, d);
    wr(CTRL_STATUS_ADDR, 8'h00);
    rd(CTRL_STATUS_ADDR, d);
    check("off track", 1'b0, trackActive);
  endtask

  task automatic run_src(logic [1:0] src);
    logic [7:0] ctl;
    logic [7:0] d;
    int trk;
    ctl = {2'b11, 2'b00, src, 2'b00};
    trk = 0;
    wr(CTRL_STATUS_ADDR, ctl | 8'h10);
    partner.fire(src == 2'b01 ? 2'b10 : src == 2'b11 ? 2'b01 : 2'b11);
    repeat (3) @(negedge clk);
    check("wrong source", 1'b0, convertActive);
    if (src == 2'b10)
    begin
      partner.strobe(1'b0);
      repeat (3) @(negedge clk);
      check("strobe track", 1'b1, trackActive);
      partner.strobe(1'b1);
    end
    else if (src == 2'b00)
      wr(CTRL_STATUS_ADDR, ctl | 8'h10);
    else
      partner.fire({src[1], ~src[1]});
    for (int i = 0; i < 40 && !convertActive; i++)
    begin
      @(negedge clk);
      trk += trackActive;
    end
    if (src != 2'b10)
      check("track len", 1'b1, trk >= TRACK_SAR_CLKS * SAR_CLK_DIV - 1
        && trk <= TRACK_SAR_CLKS * SAR_CLK_DIV + 1);
    partner.fire(2'b11);
    wait_irq;
    rd(CTRL_STATUS_ADDR, d);
    check("status", ctl | 8'h20, d);
    wr(CTRL_STATUS_ADDR, ctl);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    #100000;
    fails++;
    tally_and_finish;
  end

  initial
  begin
    nrst = 1'b0;
    sfrAddr = 8'h00;
    sfrWrData = 8'h00;
    sfrWrite = 1'b0;
    sfrRead = 1'b0;
    windowMatch = 1'b0;
    convIrqEnable = 1'b1;
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    s_power;
    for (int s = 0; s < 4; s++)
      run_src(s[1:0]);
    tally_and_finish;
  end
endmodule

`default_nettype wire
